// >>> logic/goc_consts.svh
// register offsets, field positions, reset values and source codes
// for the output control block; definitions only
`ifndef GOC_CONSTS_SVH
`define GOC_CONSTS_SVH

`define GOC_ADDR_W 8
`define GOC_DATA_W 8
`define GOC_SEL_W 5

`define GOC_OFS_LEVEL 8'h56
`define GOC_OFS_POLARITY 8'h57
`define GOC_OFS_DIE_ID 8'h58

`define GOC_RST_LEVEL 8'h00
`define GOC_RST_POLARITY 8'h00

`define GOC_BIT_SERIAL 5
`define GOC_BIT_MUTE 4

`define GOC_SRC_REGISTER 5'h02
`define GOC_SRC_OFFSET_CAL 5'h15
`define GOC_SRC_BOOT_DONE 5'h1a

// arbitrary neutral identification value
`define GOC_DIE_ID_DEFAULT 8'h5a

`endif

// >>> logic/goc_pkg.sv
// types shared by the output control block
// assumes goc_consts.svh is on the include path
`include "goc_consts.svh"

package goc_pkg;

  typedef logic [`GOC_SEL_W-1:0] goc_src_t;
  typedef logic [`GOC_DATA_W-1:0] goc_byte_t;
  typedef logic [`GOC_ADDR_W-1:0] goc_addr_t;

endpackage : goc_pkg

// >>> logic/goc_pin_drive.sv
// one output pin: source selection followed by polarity inversion
// assumes select code and flags come from logic on the same clock
`timescale 1ns/10ps
`include "goc_consts.svh"

module goc_pin_drive
  import goc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // selection and control bits
  input wire goc_src_t sel,
  input wire logic level_bit,
  input wire logic invert_bit,
  // internal flags
  input wire logic boot_done_flag,
  input wire logic offset_cal_flag,
  // pin level
  output logic pin_q
);

  logic selected;
  logic next_pin_q;

  always_comb begin
    unique case (sel)
      `GOC_SRC_REGISTER: selected = level_bit;
      `GOC_SRC_OFFSET_CAL: selected = offset_cal_flag;
      `GOC_SRC_BOOT_DONE: selected = boot_done_flag;
      // codes outside this block's reach select zero, so the pin drives the invert bit
      default: selected = 1'b0;
    endcase
    next_pin_q = selected ^ invert_bit;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= next_pin_q;
    end
  end

endmodule : goc_pin_drive

// >>> logic/goc_output_control.sv
// output control: level and polarity registers, die identification,
// and drive of the serial data out pin and the mute output
// holds no state beyond the two control registers, the read answer and the per-pin output flops
// assumes the register port and source selects are synchronous to mclk
// assumes the boot-done and calibration flags come from logic on mclk,
// so they reach the pin muxes without a synchroniser
`timescale 1ns/10ps
`include "goc_consts.svh"

module goc_output_control
  import goc_pkg::*;
#(
  parameter goc_byte_t DIE_ID = `GOC_DIE_ID_DEFAULT,
  parameter int NUM_PINS = 2
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register address and write data
  input wire goc_addr_t reg_addr,
  input wire goc_byte_t reg_wdata,
  // register strobes
  input wire logic reg_wr,
  input wire logic reg_rd,
  // register read answer
  output goc_byte_t reg_rdata,
  output logic reg_rvalid,
  // source selections held elsewhere
  input wire goc_src_t serial_out_source_select,
  input wire goc_src_t mute_source_select,
  // internal flags
  input wire logic boot_done_flag,
  input wire logic offset_cal_flag,
  // pins
  output logic serial_data_out_pin,
  output logic mute_out
);

  // control registers
  goc_byte_t output_level_control;
  goc_byte_t output_polarity_control;
  goc_byte_t next_output_level_control;
  goc_byte_t next_output_polarity_control;

  // write strobes, one per writable register
  logic level_wr_en;
  logic polarity_wr_en;

  // read path
  goc_byte_t next_reg_rdata;
  logic next_reg_rvalid;
  goc_byte_t read_mux;

  // per-pin wiring
  goc_src_t pin_sel [NUM_PINS];
  logic pin_level [NUM_PINS];
  logic pin_invert [NUM_PINS];
  logic pin_drive [NUM_PINS];

  // serial pin control bits
  logic serial_out_pin_level;
  logic serial_out_pin_invert;

  // mute output control bits
  logic mute_level;
  logic mute_invert;

  // read-only identification; the write decode drops writes to it
  goc_byte_t die_ident_value;

  assign die_ident_value = DIE_ID;

  assign serial_out_pin_level = output_level_control[`GOC_BIT_SERIAL];
  assign mute_level = output_level_control[`GOC_BIT_MUTE];
  assign serial_out_pin_invert = output_polarity_control[`GOC_BIT_SERIAL];
  assign mute_invert = output_polarity_control[`GOC_BIT_MUTE];

  // write decode; the die id and unmapped addresses fall through,
  // so a stray write never disturbs the pin controls
  always_comb begin
    level_wr_en = 1'b0;
    polarity_wr_en = 1'b0;
    if (reg_wr) begin
      unique case (reg_addr)
        `GOC_OFS_LEVEL: begin
          level_wr_en = 1'b1;
        end
        `GOC_OFS_POLARITY: begin
          polarity_wr_en = 1'b1;
        end
        // die id is read only, other addresses ignored
        default: begin
        end
      endcase
    end
  end

  // level register, reset 0
  // reserved bits are kept as plain storage and read back
  // a write takes the whole byte; no field is masked
  always_comb begin
    next_output_level_control = output_level_control;
    if (level_wr_en) begin
      next_output_level_control = reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      output_level_control <= `GOC_RST_LEVEL;
    end else begin
      output_level_control <= next_output_level_control;
    end
  end

  // polarity register, reset 0
  // inversion applies to whatever source a pin has selected
  always_comb begin
    next_output_polarity_control = output_polarity_control;
    if (polarity_wr_en) begin
      next_output_polarity_control = reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      output_polarity_control <= `GOC_RST_POLARITY;
    end else begin
      output_polarity_control <= next_output_polarity_control;
    end
  end

  // register reads; unmapped addresses read as zero
  always_comb begin
    unique case (reg_addr)
      `GOC_OFS_LEVEL: read_mux = output_level_control;
      `GOC_OFS_POLARITY: read_mux = output_polarity_control;
      `GOC_OFS_DIE_ID: read_mux = die_ident_value;
      default: read_mux = 8'h00;
    endcase
  end

  // a read in the same cycle as a write returns the old value, since
  // the mux looks at the registers before the write lands
  always_comb begin
    next_reg_rdata = reg_rdata;
    // data holds between reads so a slow reader can sample late
    if (reg_rd) begin
      next_reg_rdata = read_mux;
    end
  end

  // read data resets to zero so it is defined before the first read
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // valid marks the single cycle in which fresh read data appears
  always_comb begin
    next_reg_rvalid = reg_rd;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= next_reg_rvalid;
    end
  end

  // NUM_PINS sizes the arrays and the driver loop; the two pin assignments below are
  // fixed, so a wider build needs more sources wired in
  // pin 0 is the serial data out pin
  assign pin_sel[0] = serial_out_source_select;
  assign pin_level[0] = serial_out_pin_level;
  assign pin_invert[0] = serial_out_pin_invert;

  // pin 1 is the mute output
  assign pin_sel[1] = mute_source_select;
  assign pin_level[1] = mute_level;
  assign pin_invert[1] = mute_invert;

  // one registered driver per pin, so the pins never glitch on a
  // select change and the top outputs come straight from flops;
  // a register write shows at the pins one clock after it lands
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    goc_pin_drive u_drive (
      .mclk(mclk),
      .nrst(nrst),
      .sel(pin_sel[i]),
      .level_bit(pin_level[i]),
      .invert_bit(pin_invert[i]),
      .boot_done_flag(boot_done_flag),
      .offset_cal_flag(offset_cal_flag),
      .pin_q(pin_drive[i])
    );
  end

  // top outputs taken straight from the per-pin flops
  assign serial_data_out_pin = pin_drive[0];
  assign mute_out = pin_drive[1];

endmodule : goc_output_control

// >>> dv/goc_pin_load.sv
// external load on the two pins; levels pass straight through
// assumes push-pull pins driven by the block at all times
`timescale 1ns/10ps
module goc_pin_load (
  // pins in, levels seen out
  input wire logic [1:0] pins,
  output logic [1:0] seen
);
  assign seen = pins;
endmodule : goc_pin_load

// >>> dv/goc_oc_asserts.sv
// pin drive checks for the output control block
// assumes it is bound onto goc_output_control
`timescale 1ns/10ps
module goc_oc_asserts
  import goc_pkg::*;
(
  // clock, reset, writes
  input wire logic mclk,
  input wire logic nrst,
  input wire goc_addr_t reg_addr,
  input wire goc_byte_t reg_wdata,
  input wire logic reg_wr,
  // selects, flags, pins
  input wire goc_src_t serial_out_source_select,
  input wire goc_src_t mute_source_select,
  input wire logic boot_done_flag,
  input wire logic offset_cal_flag,
  input wire logic serial_data_out_pin,
  input wire logic mute_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire [4:0] s = serial_out_source_select;
  wire [4:0] m = mute_source_select;
  wire sp = serial_data_out_pin;
  wire mp = mute_out;
  goc_byte_t lv, pv;
  // mirror of the registers, so pins can be predicted from writes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lv <= 8'h00;
      pv <= 8'h00;
    end else if (reg_wr && reg_addr == 8'h56) begin
      lv <= reg_wdata;
    end else if (reg_wr && reg_addr == 8'h57) begin
      pv <= reg_wdata;
    end
  end
  chk_sd_boot: assert property ($past(nrst && s == 5'h1a) |->
    sp == $past(boot_done_flag ^ pv[5])) else $error("sd boot");
  chk_mute_cal: assert property ($past(nrst && m == 5'h15) |->
    mp == $past(offset_cal_flag ^ pv[4])) else $error("mute cal");
  chk_sd_level: assert property (
    $past(nrst && s == 5'h02 && !pv[5]) |-> sp == $past(lv[5]))
    else $error("sd level");
  chk_mute_level: assert property (
    $past(nrst && m == 5'h02 && !pv[4]) |-> mp == $past(lv[4]))
    else $error("mute level");
  chk_sd_invert: assert property ($past(nrst && s == 5'h00) |->
    sp == $past(pv[5])) else $error("sd invert");
  chk_mute_invert: assert property ($past(nrst && m == 5'h00) |->
    mp == $past(pv[4])) else $error("mute invert");
  // serial pin on its register level with inversion on, then a clock
  sequence sd_reg_inverted;
    (s == 5'h02 && pv[5]) ##1 nrst;
  endsequence
  chk_invert_after: assert property (sd_reg_inverted |->
    sp == !$past(lv[5])) else $error("invert order");
endmodule : goc_oc_asserts
bind goc_output_control goc_oc_asserts u_goc_oc_asserts (.*);

// >>> dv/tb.sv
// testbench for the output control block
// assumes the checker binds itself onto the design
`timescale 1ns/10ps
`include "goc_consts.svh"
module tb;
  import goc_pkg::*;
  logic mclk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic boot_done_flag = 1'h0, offset_cal_flag = 1'h0;
  goc_addr_t reg_addr = 8'h00;
  goc_byte_t reg_wdata = 8'h00, reg_rdata;
  goc_src_t serial_out_source_select = 5'h00, mute_source_select = 5'h00;
  logic reg_rvalid, serial_data_out_pin, mute_out;
  logic [1:0] seen;
  int failures = 0, tests_run = 0, cyc = 0;
  goc_output_control u_goc_output_control (.*);
  goc_pin_load u_goc_pin_load (.pins({serial_data_out_pin, mute_out}),
    .seen(seen));
  initial forever #20 mclk = ~mclk;
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one register access; returns once pins reflect a write
  task automatic acc(logic w, goc_addr_t a, goc_byte_t d);
    @(negedge mclk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    // a read answers with a one-cycle valid pulse, a write with none
    chk("rvalid", reg_rvalid, {7'h00, !w});
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    @(negedge mclk);
    chk("rvalid low", reg_rvalid, 8'h00);
  endtask : acc
  function automatic logic ex(goc_src_t c, logic l);
    return c == 5'h02 ? l : c == 5'h15 ? offset_cal_flag :
      c == 5'h1a ? boot_done_flag : 1'h0;
  endfunction : ex
  task automatic t_regs;
    chk("pins", seen, 2'h0);
    acc(1'h0, 8'h56, 8'h00);
    chk("level", reg_rdata, 8'h00);
    acc(1'h0, 8'h57, 8'h00);
    chk("polarity", reg_rdata, 8'h00);
    acc(1'h1, 8'h56, 8'hc3);
    acc(1'h0, 8'h56, 8'h00);
    chk("level rw", reg_rdata, 8'hc3);
    acc(1'h0, 8'h60, 8'h00);
    chk("unmapped", reg_rdata, 8'h00);
    acc(1'h1, 8'h58, 8'hff);
    acc(1'h0, 8'h58, 8'h00);
    chk("die id", reg_rdata, `GOC_DIE_ID_DEFAULT);
  endtask : t_regs
  // mid-run reset clears the level register and drops the pins
  task automatic t_reset;
    serial_out_source_select = 5'h02;
    mute_source_select = 5'h02;
    acc(1'h1, 8'h56, 8'hff);
    acc(1'h1, 8'h57, 8'hcf);
    chk("pins set", seen, 2'h3);
    acc(1'h0, 8'h57, 8'h00);
    chk("polarity rw", reg_rdata, 8'hcf);
    @(negedge mclk);
    nrst = 1'h0;
    @(negedge mclk);
    chk("pins in reset", seen, 2'h0);
    nrst = 1'h1;
    acc(1'h0, 8'h56, 8'h00);
    chk("level reset", reg_rdata, 8'h00);
    chk("pins after", seen, 2'h0);
  endtask : t_reset
  task automatic t_pins;
    goc_src_t c[4] = '{5'h02, 5'h15, 5'h1a, 5'h00};
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 32; i++) begin
        serial_out_source_select = c[k];
        mute_source_select = c[3 - k];
        boot_done_flag = i[0];
        offset_cal_flag = i[1];
        acc(1'h1, 8'h56, {2'h0, {2{i[2]}}, 4'h0});
        acc(1'h1, 8'h57, {2'h0, i[3], i[4], 4'h0});
        chk("sd", seen[1], ex(c[k], i[2]) ^ i[3]);
        chk("mute", seen[0], ex(c[3 - k], i[2]) ^ i[4]);
      end
    end
  endtask : t_pins
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    repeat (2) @(negedge mclk);
    nrst = 1'h1;
    t_regs();
    t_reset();
    t_pins();
    report_and_stop();
  end
endmodule : tb
